// File: rtl/sar_adc_channel_sequencer.sv
// Function
// - Each result is 12 bits; aggregate rate reaches 806 thousand samples/s (here at most about 731: divider 9, 19 converter clocks per result).
// - A conversion lasts 18 converter clocks; converter clock at most 14.5 MHz.
// - Reference is supply, half supply, 1.024 V internal, or external pin.
// - Sample time is programmable separately for every channel.
// - Eight-input sequencer steps through enabled channels by itself.
// - No idle cycles between channels of a scan.
// - Channels switch by scan state machine or firmware selection.
// - Every channel keeps its own result buffer.
// - Results outside low/high limits raise out-of-range interrupt at once.
// - Temperature sensor is a selectable conversion input.
// - Converter unavailable in deep sleep or hibernate.
//
// Local design decisions: the placing of the registers and register access over Avalon-MM.
module sar_adc_channel_sequencer #(
    parameter int NUM_SAMPLE_W = 8
) (
    // System.
    input wire logic clk_sys,
    input wire logic rst_b,
    // Power state: high while in deep sleep or hibernate.
    input wire logic low_power_mode,
    // Register bus.
    input wire sar_seq_pkg::avmm_req_t bus_req,
    output sar_seq_pkg::avmm_rsp_t bus_rsp,
    // Analog front end.
    output sar_seq_pkg::analog_ctl_t analog_ctl,
    input wire logic comp_out,
    // Interrupt.
    output logic irq
);
    import sar_seq_pkg::*;

    typedef enum {IDLE, SAMPLE, CONVERT} seq_state_t;

    ////////////////////////////////////////////////////////////////////////
    // Registers.
    logic enable;
    switch_mode_t mode;
    logic continuous;
    ref_sel_t ref_sel;
    logic [CH_W-1:0] fw_channel;
    logic [7:0] clk_div;
    logic [NUM_CH-1:0] chan_en;
    logic [2:0] int_stat;
    logic [2:0] int_mask;
    logic [RESULT_W-1:0] range_low;
    logic [RESULT_W-1:0] range_high;
    logic [NUM_CH-1:0] range_flag;
    logic [NUM_SAMPLE_W-1:0] sample_time [NUM_CH];
    logic [RESULT_W-1:0] result [NUM_CH];

    seq_state_t state;
    logic [CH_W-1:0] channel;
    // Channel whose conversion just ended; when a scan goes on to another input, channel itself has moved on.
    logic [CH_W-1:0] done_ch;
    logic rd_ack;
    logic [7:0] div_cnt;
    logic conv_tick;
    logic [NUM_SAMPLE_W-1:0] samp_cnt;
    logic [4:0] bit_cnt;
    logic [RESULT_W-1:0] sar_reg;
    logic done_pulse;
    logic scan_end_pulse;
    logic range_hit;
    logic start_req;
    logic available;

    logic wr;
    logic rd;
    logic [CH_W-1:0] next_channel;
    logic next_found;

    assign wr = bus_req.write;
    assign rd = bus_req.read;
    // Writes complete at once; a read waits one cycle so that its
    // registered data already stand at the edge that accepts it.
    assign bus_rsp.waitrequest = rd && !rd_ack;

    always_ff @(posedge clk_sys) begin
        if (!rst_b) begin
            rd_ack <= 1'b0;
        end else begin
            rd_ack <= rd && !rd_ack;
        end
    end

    // The high-speed clock is gone in deep power modes.
    assign available = enable && !low_power_mode;

    always_ff @(posedge clk_sys) begin
        if (!rst_b) begin
            enable <= 1'b0;
            mode <= SWITCH_SCAN;
            continuous <= 1'b0;
            ref_sel <= REF_VDD;
            fw_channel <= '0;
            clk_div <= CLK_DIV_RESET;
            start_req <= 1'b0;
        end else begin
            if (state == IDLE && available
                && (mode == SWITCH_FIRMWARE || chan_en != '0)) begin
                start_req <= 1'b0;
            end
            if (wr && bus_req.address == CTRL_OFS) begin
                enable <= bus_req.writedata[CTRL_ENABLE_BIT];
                mode <= switch_mode_t'(bus_req.writedata[CTRL_MODE_BIT]);
                continuous <= bus_req.writedata[CTRL_CONT_BIT];
                ref_sel <= ref_sel_t'(
                    bus_req.writedata[CTRL_REF_LSB +: 2]);
                fw_channel <= bus_req.writedata[CTRL_FWCH_LSB +: CH_W];
                // Dividers below the floor would overclock the converter.
                if (bus_req.writedata[CTRL_DIV_LSB +: 8] >= CLK_DIV_RESET) begin
                    clk_div <= bus_req.writedata[CTRL_DIV_LSB +: 8];
                end
                if (bus_req.writedata[CTRL_START_BIT]) begin
                    start_req <= 1'b1;
                end
            end
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!rst_b) begin
            chan_en <= CHAN_EN_RESET;
            range_low <= '0;
            range_high <= '1;
        end else begin
            if (wr && bus_req.address == CHAN_EN_OFS) begin
                chan_en <= bus_req.writedata[NUM_CH-1:0];
            end
            if (wr && bus_req.address == RANGE_OFS) begin
                range_low <= bus_req.writedata[RESULT_W-1:0];
                range_high <= bus_req.writedata[16 +: RESULT_W];
            end
        end
    end

    // Per-channel sample times, one word each.
    generate
        for (genvar i = 0; i < NUM_CH; i++) begin : g_samp
            always_ff @(posedge clk_sys) begin
                if (!rst_b) begin
                    sample_time[i] <= NUM_SAMPLE_W'(SAMPLE_RESET);
                end else if (wr && bus_req.address ==
                             SAMPLE_OFS + 8'(4 * i)) begin
                    sample_time[i] <=
                        bus_req.writedata[NUM_SAMPLE_W-1:0];
                end
            end
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////
    // Converter clock enable.
    always_ff @(posedge clk_sys) begin
        if (!rst_b || state == IDLE) begin
            // Starting at one makes the first tick a full period away.
            div_cnt <= 8'h01;
            conv_tick <= 1'b0;
        end else if (div_cnt >= clk_div - 8'h01) begin
            div_cnt <= '0;
            conv_tick <= 1'b1;
        end else begin
            div_cnt <= div_cnt + 8'h01;
            conv_tick <= 1'b0;
        end
    end

    // Next enabled channel above the current one, for the scan.
    always_comb begin
        next_channel = channel;
        next_found = 1'b0;
        for (int i = NUM_CH - 1; i >= 0; i--) begin
            if (chan_en[i] && CH_W'(i) > channel) begin
                next_channel = CH_W'(i);
                next_found = 1'b1;
            end
        end
    end

    function automatic logic [CH_W-1:0] first_enabled(
        input logic [NUM_CH-1:0] en
    );
        logic [CH_W-1:0] f;
        f = '0;
        for (int i = NUM_CH - 1; i >= 0; i--) begin
            if (en[i]) begin
                f = CH_W'(i);
            end
        end
        return f;
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // Sequencer.
    always_ff @(posedge clk_sys) begin
        if (!rst_b) begin
            state <= IDLE;
            channel <= '0;
            done_ch <= '0;
            samp_cnt <= '0;
            bit_cnt <= '0;
            sar_reg <= '0;
            done_pulse <= 1'b0;
            scan_end_pulse <= 1'b0;
        end else begin
            done_pulse <= 1'b0;
            scan_end_pulse <= 1'b0;
            if (!available) begin
                state <= IDLE;
            end else begin
                unique case (state)
                    IDLE: begin
                        if (start_req && (mode == SWITCH_FIRMWARE
                                          || chan_en != '0)) begin
                            state <= SAMPLE;
                            samp_cnt <= '0;
                            channel <= (mode == SWITCH_FIRMWARE) ?
                                fw_channel : first_enabled(chan_en);
                        end
                    end
                    SAMPLE: begin
                        if (conv_tick) begin
                            if (samp_cnt >= sample_time[channel]) begin
                                state <= CONVERT;
                                bit_cnt <= '0;
                                sar_reg <= '0;
                            end else begin
                                samp_cnt <= samp_cnt + 1'b1;
                            end
                        end
                    end
                    CONVERT: begin
                        if (conv_tick) begin
                            if (bit_cnt < 5'(RESULT_W)) begin
                                sar_reg[RESULT_W-1-bit_cnt] <= comp_out;
                            end
                            bit_cnt <= bit_cnt + 5'h01;
                            if (bit_cnt == 5'(CONV_CYCLES - 1)) begin
                                done_pulse <= 1'b1;
                                done_ch <= channel;
                                samp_cnt <= '0;
                                if (mode == SWITCH_SCAN && next_found) begin
                                    // Straight into the next sample.
                                    channel <= next_channel;
                                    state <= SAMPLE;
                                end else begin
                                    if (mode == SWITCH_SCAN) begin
                                        scan_end_pulse <= 1'b1;
                                    end
                                    if (continuous) begin
                                        state <= SAMPLE;
                                        channel <= (mode == SWITCH_SCAN) ?
                                            first_enabled(chan_en) :
                                            fw_channel;
                                    end else begin
                                        state <= IDLE;
                                    end
                                end
                            end
                        end
                    end
                endcase
            end
        end
    end

    // Result buffer per channel, 12 bits wide.
    always_ff @(posedge clk_sys) begin
        if (!rst_b) begin
            for (int i = 0; i < NUM_CH; i++) begin
                result[i] <= '0;
            end
        end else if (done_pulse) begin
            result[done_ch] <= sar_reg;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Range check and interrupts.
    assign range_hit = done_pulse &&
        (sar_reg < range_low || sar_reg > range_high);

    always_ff @(posedge clk_sys) begin
        if (!rst_b) begin
            range_flag <= '0;
        end else begin
            for (int i = 0; i < NUM_CH; i++) begin
                if (range_hit && done_ch == CH_W'(i)) begin
                    range_flag[i] <= 1'b1;
                end else if (wr && bus_req.address == RANGE_FLAG_OFS
                             && bus_req.writedata[i]) begin
                    range_flag[i] <= 1'b0;
                end
            end
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!rst_b) begin
            int_stat <= '0;
            int_mask <= '0;
        end else begin
            for (int i = 0; i < 3; i++) begin
                if ((i == INT_DONE_BIT && done_pulse)
                    || (i == INT_RANGE_BIT && range_hit)
                    || (i == INT_SCAN_BIT && scan_end_pulse)) begin
                    int_stat[i] <= 1'b1;
                end else if (wr && bus_req.address == INT_STAT_OFS
                             && bus_req.writedata[i]) begin
                    int_stat[i] <= 1'b0;
                end
            end
            if (wr && bus_req.address == INT_MASK_OFS) begin
                int_mask <= bus_req.writedata[2:0];
            end
        end
    end

    assign irq = |(int_stat & int_mask);

    ////////////////////////////////////////////////////////////////////////
    // Analog side controls.
    always_ff @(posedge clk_sys) begin
        if (!rst_b) begin
            analog_ctl <= '0;
        end else begin
            analog_ctl.channel <= channel;
            analog_ctl.ref_sel <= ref_sel;
            analog_ctl.sample <= state == SAMPLE;
            analog_ctl.convert <= state == CONVERT;
            analog_ctl.temp_sensor_en <= available &&
                channel == CH_W'(TEMP_CH);
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Read data.
    always_ff @(posedge clk_sys) begin
        if (!rst_b) begin
            bus_rsp.readdata <= '0;
        end else if (rd) begin
            bus_rsp.readdata <= '0;
            if (bus_req.address == CTRL_OFS) begin
                bus_rsp.readdata <= {8'h00, clk_div, 3'h0, 1'b0, fw_channel,
                    2'h0, ref_sel, continuous, start_req, mode, enable};
            end else if (bus_req.address == CHAN_EN_OFS) begin
                bus_rsp.readdata[NUM_CH-1:0] <= chan_en;
            end else if (bus_req.address == STATUS_OFS) begin
                bus_rsp.readdata <= {24'h0, channel, 1'b0, low_power_mode,
                    state != IDLE ? 2'b01 : 2'b00};
            end else if (bus_req.address == INT_STAT_OFS) begin
                bus_rsp.readdata[2:0] <= int_stat;
            end else if (bus_req.address == INT_MASK_OFS) begin
                bus_rsp.readdata[2:0] <= int_mask;
            end else if (bus_req.address == RANGE_OFS) begin
                bus_rsp.readdata <= {4'h0, range_high, 4'h0, range_low};
            end else if (bus_req.address == RANGE_FLAG_OFS) begin
                bus_rsp.readdata[NUM_CH-1:0] <= range_flag;
            end else begin
                for (int i = 0; i < NUM_CH; i++) begin
                    if (bus_req.address == SAMPLE_OFS + 8'(4 * i)) begin
                        bus_rsp.readdata[NUM_SAMPLE_W-1:0] <= sample_time[i];
                    end
                    if (bus_req.address == RESULT_OFS + 8'(4 * i)) begin
                        bus_rsp.readdata[RESULT_W-1:0] <= result[i];
                    end
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Checks.
    low_power_idle_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
        low_power_mode |=> state == IDLE)
        else $error("sequencer ran in a deep power mode");

    range_irq_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
        range_hit |=> int_stat[INT_RANGE_BIT])
        else $error("out of range result did not flag");

    result_store_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
        done_pulse |=> result[$past(done_ch)] == $past(sar_reg))
        else $error("result not stored in its channel buffer");

    no_gap_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
        done_pulse && $past(mode == SWITCH_SCAN && next_found && available)
        |-> state == SAMPLE)
        else $error("idle gap between channels");

    div_floor_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
        clk_div >= CLK_DIV_RESET)
        else $error("converter clock above its maximum");

    scan_end_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
        scan_end_pulse |-> done_pulse ##1 int_stat[INT_SCAN_BIT])
        else $error("scan completion not flagged");

    temp_sel_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
        available && channel == CH_W'(TEMP_CH)
        |=> analog_ctl.temp_sensor_en)
        else $error("temperature sensor not routed");

    fw_channel_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
        state == IDLE && available && start_req && mode == SWITCH_FIRMWARE
        |=> channel == $past(fw_channel))
        else $error("firmware channel not used");

endmodule

// File: rtl/sar_seq_pkg.sv
package sar_seq_pkg;

    localparam int RESULT_W = 12;
    localparam int NUM_INPUTS = 8;
    // Eight pins plus the temperature sensor.
    localparam int NUM_CH = 9;
    localparam int CH_W = 4;
    localparam int TEMP_CH = 8;

    // Converter clock limits and throughput.
    localparam int SYS_CLK_KHZ = 125000;
    localparam int CONV_CLK_MAX_KHZ = 14500;
    localparam int CONV_CYCLES = 18;
    localparam int MAX_KSPS = 806;
    // Least divider keeping the converter clock at or under its maximum.
    localparam int CLK_DIV_MIN =
        (SYS_CLK_KHZ + CONV_CLK_MAX_KHZ - 1) / CONV_CLK_MAX_KHZ;
    localparam logic [7:0] CLK_DIV_RESET = 8'(CLK_DIV_MIN);

    // Register byte offsets.
    localparam logic [7:0] CTRL_OFS = 8'h00;
    localparam logic [7:0] CHAN_EN_OFS = 8'h04;
    localparam logic [7:0] STATUS_OFS = 8'h08;
    localparam logic [7:0] INT_STAT_OFS = 8'h0c;
    localparam logic [7:0] INT_MASK_OFS = 8'h10;
    localparam logic [7:0] RANGE_OFS = 8'h14;
    localparam logic [7:0] RANGE_FLAG_OFS = 8'h18;
    localparam logic [7:0] SAMPLE_OFS = 8'h20;
    localparam logic [7:0] RESULT_OFS = 8'h60;

    // Control register fields.
    localparam int CTRL_ENABLE_BIT = 0;
    localparam int CTRL_MODE_BIT = 1;
    localparam int CTRL_START_BIT = 2;
    localparam int CTRL_CONT_BIT = 3;
    localparam int CTRL_REF_LSB = 4;
    localparam int CTRL_FWCH_LSB = 8;
    localparam int CTRL_DIV_LSB = 16;

    localparam logic [7:0] SAMPLE_RESET = 8'h03;
    localparam logic [NUM_CH-1:0] CHAN_EN_RESET = '0;

    // Interrupt bits.
    localparam int INT_DONE_BIT = 0;
    localparam int INT_RANGE_BIT = 1;
    localparam int INT_SCAN_BIT = 2;

    typedef enum logic [1:0] {
        REF_VDD,
        REF_VDD_HALF,
        REF_INT_1V024,
        REF_EXT_PIN
    } ref_sel_t;

    typedef enum logic {
        SWITCH_SCAN,
        SWITCH_FIRMWARE
    } switch_mode_t;

    typedef struct packed {
        logic [7:0] address;
        logic read;
        logic write;
        logic [31:0] writedata;
    } avmm_req_t;

    typedef struct packed {
        logic [31:0] readdata;
        logic waitrequest;
    } avmm_rsp_t;

    typedef struct packed {
        logic [CH_W-1:0] channel;
        ref_sel_t ref_sel;
        logic sample;
        logic convert;
        logic temp_sensor_en;
    } analog_ctl_t;

endpackage

// File: test/analog_front_model.sv
module analog_front_model import sar_seq_pkg::*; (
    // Clock.
    input wire logic clk_sys,
    // Converter side.
    input wire sar_seq_pkg::analog_ctl_t analog_ctl,
    input wire logic [7:0] div,
    output logic comp_out
);
    timeunit 1ns;
    timeprecision 1ps;

    logic [RESULT_W-1:0] level;
    logic junk = 1'b0;
    int ticks = 0;
    int idx;

    // Input i carries code {i, a5}; input 8 is the temperature sensor.
    assign level = {analog_ctl.channel, 8'ha5};
    assign idx = ticks / int'(div);
    // The comparator answers each trial with the code bit of that tick, so
    // the successive decisions rebuild the code. Outside the bit window the
    // line toggles every cycle, so a stray sample never looks plausible.
    assign comp_out = (analog_ctl.convert && idx < RESULT_W) ?
        level[RESULT_W-1-idx] : junk;

    always @(posedge clk_sys) begin
        junk <= ~junk;
        ticks <= analog_ctl.convert ? ticks + 1 : 0;
    end
endmodule

// File: test/tb_sar_adc_channel_sequencer.sv
module tb_sar_adc_channel_sequencer import sar_seq_pkg::*;;
    timeunit 1ns;
    timeprecision 1ps;

    logic clk_sys = 1'b0;
    logic rst_b = 1'b0;
    logic low_power_mode = 1'b0;
    avmm_req_t bus_req = '0;
    avmm_rsp_t bus_rsp;
    analog_ctl_t analog_ctl;
    logic comp_out;
    logic irq;
    int n_fail = 0;
    int tests_run = 0;
    logic [7:0] div = 8'h09;
    logic [7:0] st_exp [NUM_CH];
    logic [31:0] rdata;
    logic armed = 1'b0;
    int conv_left = 0;
    int cyc = 0;
    int last_end = 0;
    int samp_len = 0;
    int conv_len = 0;
    int n_conv = 0;
    int n_keep;
    logic [CH_W-1:0] cap_ch;
    ref_sel_t cap_ref;
    logic cap_temp;

    always #4 clk_sys = ~clk_sys;

    sar_adc_channel_sequencer i_dut (
        .clk_sys(clk_sys),
        .rst_b(rst_b),
        .low_power_mode(low_power_mode),
        .bus_req(bus_req),
        .bus_rsp(bus_rsp),
        .analog_ctl(analog_ctl),
        .comp_out(comp_out),
        .irq(irq)
    );

    analog_front_model i_model (
        .clk_sys(clk_sys),
        .analog_ctl(analog_ctl),
        .div(div),
        .comp_out(comp_out)
    );

    ////////////////////////////////////////////////////////////////////////
    task automatic final_report;
        if (n_fail == 0 && tests_run > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            n_fail++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // Slave outputs only move at rising edges, so what stands mid-cycle is
    // what the next rising edge sees.
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic ws;
        bus_req.address <= a;
        bus_req.writedata <= d;
        bus_req.write <= 1'b1;
        do begin
            @(negedge clk_sys);
            ws = bus_rsp.waitrequest;
            @(posedge clk_sys);
        end while (ws !== 1'b0);
        bus_req.write <= 1'b0;
        @(posedge clk_sys);
    endtask

    task automatic rd(input logic [7:0] a, output logic [31:0] d);
        logic ws;
        bus_req.address <= a;
        bus_req.read <= 1'b1;
        do begin
            @(negedge clk_sys);
            ws = bus_rsp.waitrequest;
            d = bus_rsp.readdata;
            @(posedge clk_sys);
        end while (ws !== 1'b0);
        bus_req.read <= 1'b0;
        @(posedge clk_sys);
    endtask

    task automatic wait_int(input int b);
        int k;
        k = 0;
        rdata = '0;
        while (rdata[b] !== 1'b1 && k < 400) begin
            rd(INT_STAT_OFS, rdata);
            k++;
        end
        chk(32'(rdata[b]), 32'h1);
    endtask

    function automatic logic [31:0] ctrl(input logic m, input logic [1:0] r,
                                         input logic [3:0] c);
        return {8'h00, div, 4'h0, c, 2'b00, r, 1'b0, 1'b1, m, 1'b1};
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // Phase monitor: sample and convert lengths and the gap inside a scan.
    always @(posedge clk_sys) begin
        cyc++;
        if (analog_ctl.sample) begin
            samp_len++;
        end else if (samp_len != 0) begin
            chk(samp_len, 32'(st_exp[analog_ctl.channel] + 1) * div);
            samp_len = 0;
        end
        if (analog_ctl.convert) begin
            conv_len++;
            cap_ch = analog_ctl.channel;
            cap_ref = analog_ctl.ref_sel;
            cap_temp = analog_ctl.temp_sensor_en;
        end else if (conv_len != 0) begin
            chk(conv_len, CONV_CYCLES * div);
            conv_len = 0;
            n_conv++;
            last_end = cyc;
            armed = conv_left > 1;
            conv_left--;
        end
        // Checked after the convert end is seen, so no cycle may separate
        // the end of one conversion from the next sample.
        if (analog_ctl.sample && samp_len == 1 && armed) begin
            chk(32'(cyc - last_end > 0), 32'h0);
            armed = 1'b0;
        end
    end

    initial begin
        repeat (60000) @(posedge clk_sys);
        n_fail++;
        final_report;
    end

    ////////////////////////////////////////////////////////////////////////
    initial begin
        foreach (st_exp[i]) st_exp[i] = SAMPLE_RESET;
        repeat (10) @(posedge clk_sys);
        rst_b <= 1'b1;
        @(posedge clk_sys);
        rd(CTRL_OFS, rdata);
        chk(rdata, {8'h00, CLK_DIV_RESET, 16'h0000});
        rd(RANGE_OFS, rdata);
        chk(rdata, 32'h0fff0000);
        rd(8'h1c, rdata);
        chk(rdata, 32'h0);
        chk(32'(irq), 32'h0);
        // A divider under the minimum would overclock the converter.
        wr(CTRL_OFS, 32'h00050000);
        rd(CTRL_OFS, rdata);
        chk(rdata, {8'h00, CLK_DIV_RESET, 16'h0000});
        div = 8'h0a;
        for (int i = 0; i < NUM_CH; i++) begin
            rd(SAMPLE_OFS + 8'(4 * i), rdata);
            chk(rdata, 32'(SAMPLE_RESET));
            st_exp[i] = 8'(i);
            wr(SAMPLE_OFS + 8'(4 * i), 32'(i));
        end
        // Firmware steps every input, each reference in turn.
        for (int i = 0; i < NUM_CH; i++) begin
            wr(CTRL_OFS, ctrl(1'b1, 2'(i), 4'(i)));
            wait_int(INT_DONE_BIT);
            rd(RESULT_OFS + 8'(4 * i), rdata);
            chk(rdata, {20'h0, 4'(i), 8'ha5});
            chk(32'(cap_ch), 32'(i));
            chk(32'(cap_ref), 32'(i % 4));
            chk(32'(cap_temp), 32'(i == TEMP_CH));
            wr(INT_STAT_OFS, 32'h7);
        end
        // Scan of inputs 0, 3 and 8 against a window of 0x200..0x600.
        wr(RANGE_OFS, 32'h06000200);
        wr(CHAN_EN_OFS, 32'h109);
        conv_left = 3;
        wr(CTRL_OFS, ctrl(1'b0, 2'd0, 4'd0));
        wait_int(INT_SCAN_BIT);
        chk(32'(n_conv), 32'(NUM_CH + 3));
        rd(INT_STAT_OFS, rdata);
        chk(rdata, 32'h7);
        rd(RANGE_FLAG_OFS, rdata);
        chk(rdata, 32'h101);
        for (int i = 0; i < NUM_CH; i++) begin
            rd(RESULT_OFS + 8'(4 * i), rdata);
            chk(rdata, {20'h0, 4'(i), 8'ha5});
        end
        chk(32'(irq), 32'h0);
        wr(INT_MASK_OFS, 32'h2);
        chk(32'(irq), 32'h1);
        wr(INT_STAT_OFS, 32'h2);
        chk(32'(irq), 32'h0);
        // No conversion may run while the fast clock is stopped.
        low_power_mode <= 1'b1;
        wr(INT_STAT_OFS, 32'h7);
        rd(STATUS_OFS, rdata);
        chk(32'(rdata[2]), 32'h1);
        n_keep = n_conv;
        wr(CTRL_OFS, ctrl(1'b1, 2'd0, 4'd1));
        repeat (400) @(posedge clk_sys);
        chk(32'(n_conv), 32'(n_keep));
        rd(INT_STAT_OFS, rdata);
        chk(rdata, 32'h0);
        low_power_mode <= 1'b0;
        final_report;
    end
endmodule
